//--- cmrp_pkg.sv
// shared constants for the clock-mode, reset and power control block
package cmrp_pkg;
    // register byte offsets
    localparam logic [11:0] CMRP_OFS_CLK_RATE = 12'h000;
    localparam logic [11:0] CMRP_OFS_PWR_CTRL = 12'h004;
    localparam logic [11:0] CMRP_OFS_STATUS = 12'h008;
    // clock_rate_select fields
    localparam int CMRP_CPU_DOUBLE_SPEED_BIT = 0;
    localparam int CMRP_HALF_RATE_LSB = 1;
    localparam int CMRP_NUM_PERIPH = 6;
    localparam logic [7:0] CMRP_CLK_RATE_RESET = 8'h00;
    localparam logic [7:0] CMRP_CLK_RATE_MASK = 8'h7F;
    // power control fields
    localparam int CMRP_IDLE_REQ_BIT = 0;
    localparam int CMRP_PDOWN_REQ_BIT = 1;
    localparam int CMRP_POWER_ON_FLAG_BIT = 4;
    localparam logic [7:0] CMRP_PWR_CTRL_MASK = 8'h13;
    // status fields
    localparam int CMRP_ST_SIX_MODE_BIT = 0;
    localparam int CMRP_ST_IDLE_BIT = 1;
    localparam int CMRP_ST_PDOWN_BIT = 2;
    localparam int CMRP_ST_EXT_PROG_BIT = 3;
    localparam int CMRP_ST_INT_RESET_BIT = 4;
    localparam int CMRP_ST_RAM_BLOCK_BIT = 5;
    // oscillator periods per machine cycle
    localparam int CMRP_OSC_PER_FAST = 6;
    localparam int CMRP_OSC_PER_SLOW = 12;
    localparam logic [3:0] CMRP_DIV_LAST = 4'hB;
    localparam logic [3:0] CMRP_DIV_MID = 4'h5;
    // reset pin must stand this many machine cycles
    localparam logic [1:0] CMRP_RESET_MC = 2'h2;
    // power-down state machine
    typedef enum logic [1:0] {
        CMRP_RUN = 2'b00,
        CMRP_IDLE = 2'b01,
        CMRP_PDOWN = 2'b10,
        CMRP_WAKE = 2'b11
    } cmrp_mode_e;
endpackage

//--- cmrp_tick_if.sv
// tick bundle between the oscillator divider and the control logic
`timescale 1ns/1ps
interface cmrp_tick_if;
    logic osc_run;
    logic tick_fast;
    logic tick_slow;
    modport div (input osc_run, output tick_fast, output tick_slow);
    modport ctl (output osc_run, input tick_fast, input tick_slow);
endinterface

//--- cmrp_osc_div.sv
// oscillator divider giving fosc/6 and fosc/12 strobes
`timescale 1ns/1ps
module cmrp_osc_div
    import cmrp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // ticks
    cmrp_tick_if.div ticks
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic fast_reg;
    logic fast_next;
    logic slow_reg;
    logic slow_next;

    always_comb begin
        cnt_next = cnt_reg;
        fast_next = 1'b0;
        slow_next = 1'b0;
        // a stopped oscillator freezes the count where it stands
        if (ticks.osc_run) begin
            cnt_next = (cnt_reg == CMRP_DIV_LAST) ? 4'h0 : cnt_reg + 4'h1;
            fast_next = (cnt_reg == CMRP_DIV_LAST) || (cnt_reg == CMRP_DIV_MID);
            slow_next = (cnt_reg == CMRP_DIV_LAST);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 4'h0;
            fast_reg <= 1'b0;
            slow_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            fast_reg <= fast_next;
            slow_reg <= slow_next;
        end
    end

    assign ticks.tick_fast = fast_reg;
    assign ticks.tick_slow = slow_reg;
endmodule

//--- cmrp_ctrl.sv
// clock mode, reset, idle and power-down control with apb registers
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module cmrp_ctrl
    import cmrp_pkg::*;
#(
    parameter int NUM_PERIPH = CMRP_NUM_PERIPH
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins and straps
    input wire logic reset_pin,
    input wire logic ext_program_select,
    input wire logic nv_double_speed,
    input wire logic ext_irq_zero_n,
    input wire logic ext_irq_one_n,
    // interrupt controller view
    input wire logic ext_irq_zero_wake_en,
    input wire logic ext_irq_one_wake_en,
    input wire logic any_enabled_irq,
    input wire logic uart_fixed_mode,
    // clocks and controls to the rest of the chip
    output logic cpu_tick,
    output logic [NUM_PERIPH-1:0] periph_tick,
    output logic uart_tick,
    output logic osc_run,
    output logic internal_reset,
    output logic ram_block,
    output logic port_reset,
    output logic ext_program_latched,
    output logic wake_irq
);
    initial begin
        if (NUM_PERIPH != CMRP_NUM_PERIPH) begin
            $error("NUM_PERIPH must match the divider select field");
        end
    end

    cmrp_tick_if ticks ();

    cmrp_osc_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .ticks(ticks)
    );

    // register state
    logic [7:0] clk_rate_reg;
    logic [7:0] clk_rate_next;
    logic idle_req_reg;
    logic idle_req_next;
    logic pdown_req_reg;
    logic pdown_req_next;
    logic pof_reg;
    logic pof_next;
    // apb answer
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    // mode and reset state
    cmrp_mode_e mode_reg;
    cmrp_mode_e mode_next;
    logic [1:0] rst_cnt_reg;
    logic [1:0] rst_cnt_next;
    logic int_rst_reg;
    logic int_rst_next;
    logic ext_prog_reg;
    logic ext_prog_next;
    logic ram_block_reg;
    logic ram_block_next;
    logic wake_irq_reg;
    logic wake_irq_next;
    // tick outputs
    logic cpu_tick_reg;
    logic cpu_tick_next;
    logic [NUM_PERIPH-1:0] periph_tick_reg;
    logic [NUM_PERIPH-1:0] periph_tick_next;
    logic uart_tick_reg;
    logic uart_tick_next;
    logic port_reset_reg;
    // oscillator enable
    logic osc_run_reg;
    logic osc_run_next;

    logic six_mode;
    logic mc_tick;
    logic wr_en;
    logic setup;
    logic irq_low;
    logic [7:0] pwr_ctrl_rd;
    logic [7:0] status_rd;

    assign six_mode = nv_double_speed || clk_rate_reg[CMRP_CPU_DOUBLE_SPEED_BIT];
    assign mc_tick = six_mode ? ticks.tick_fast : ticks.tick_slow;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
    // level-triggered, enabled external irq held low
    assign irq_low = (ext_irq_zero_wake_en && !ext_irq_zero_n) ||
                     (ext_irq_one_wake_en && !ext_irq_one_n);
    // registered enable keeps the osc_run output on a flip-flop
    assign ticks.osc_run = osc_run_reg;

    assign pwr_ctrl_rd = {3'b000, pof_reg, 2'b00, pdown_req_reg, idle_req_reg};
    assign status_rd = {2'b00, ram_block_reg, int_rst_reg, ext_prog_reg,
                        (mode_reg == CMRP_PDOWN) || (mode_reg == CMRP_WAKE),
                        mode_reg == CMRP_IDLE, six_mode};

    // apb: read data and ready are prepared in the setup cycle, so no wait states
    always_comb begin
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        if (setup) begin
            pready_next = 1'b1;
            prdata_next = 32'h0000_0000;
            case (paddr)
                CMRP_OFS_CLK_RATE: prdata_next = {24'h00_0000, clk_rate_reg};
                CMRP_OFS_PWR_CTRL: prdata_next = {24'h00_0000, pwr_ctrl_rd};
                CMRP_OFS_STATUS: prdata_next = {24'h00_0000, status_rd};
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    // software registers; internal reset restores all but the power-on flag
    always_comb begin
        clk_rate_next = clk_rate_reg;
        idle_req_next = idle_req_reg;
        pdown_req_next = pdown_req_reg;
        pof_next = pof_reg;
        if (wr_en && paddr == CMRP_OFS_CLK_RATE) begin
            clk_rate_next = pwdata[7:0] & CMRP_CLK_RATE_MASK;
        end
        if (wr_en && paddr == CMRP_OFS_PWR_CTRL) begin
            idle_req_next = pwdata[CMRP_IDLE_REQ_BIT];
            pdown_req_next = pwdata[CMRP_PDOWN_REQ_BIT];
            pof_next = pwdata[CMRP_POWER_ON_FLAG_BIT];
        end
        // a request bit drops when its mode ends
        if (mode_reg == CMRP_IDLE && mode_next == CMRP_RUN) begin
            idle_req_next = 1'b0;
        end
        if (mode_reg == CMRP_WAKE && mode_next == CMRP_RUN) begin
            pdown_req_next = 1'b0;
        end
        if (int_rst_reg) begin
            clk_rate_next = CMRP_CLK_RATE_RESET;
            idle_req_next = 1'b0;
            pdown_req_next = 1'b0;
        end
    end

    // low-power modes
    always_comb begin
        mode_next = mode_reg;
        wake_irq_next = 1'b0;
        case (mode_reg)
            CMRP_RUN: begin
                // power-down wins when both requests stand
                if (pdown_req_reg) begin
                    mode_next = CMRP_PDOWN;
                end else if (idle_req_reg) begin
                    mode_next = CMRP_IDLE;
                end
            end
            CMRP_IDLE: begin
                if (any_enabled_irq) begin
                    mode_next = CMRP_RUN;
                    wake_irq_next = 1'b1;
                end
            end
            CMRP_PDOWN: begin
                if (irq_low) begin
                    mode_next = CMRP_WAKE;
                end
            end
            CMRP_WAKE: begin
                // the oscillator is running again; the pin going high completes the exit
                if (!irq_low) begin
                    mode_next = CMRP_RUN;
                    wake_irq_next = 1'b1;
                end
            end
            default: mode_next = CMRP_RUN;
        endcase
        if (int_rst_reg) begin
            mode_next = CMRP_RUN;
            wake_irq_next = 1'b0;
        end
        // oscillator stops only while in power-down and nothing pulls it back;
        // taken from the next mode so it stops on the same edge as the mode change
        osc_run_next = !((mode_next == CMRP_PDOWN) && !irq_low && !reset_pin);
    end

    // reset pin qualification and strap latch
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        int_rst_next = int_rst_reg;
        ext_prog_next = ext_prog_reg;
        ram_block_next = ram_block_reg;
        if (!reset_pin) begin
            rst_cnt_next = 2'h0;
            int_rst_next = 1'b0;
            ram_block_next = 1'b0;
            if (int_rst_reg) begin
                ext_prog_next = ext_program_select;
            end
        end else begin
            // counts machine cycles only while the oscillator runs
            if (mc_tick && rst_cnt_reg != CMRP_RESET_MC) begin
                rst_cnt_next = rst_cnt_reg + 2'h1;
            end
            if (rst_cnt_next == CMRP_RESET_MC) begin
                int_rst_next = 1'b1;
            end
            // cpu may run on briefly out of idle; keep it off the ram meanwhile
            if (mode_reg == CMRP_IDLE && !int_rst_reg) begin
                ram_block_next = 1'b1;
            end
            if (int_rst_next) begin
                ram_block_next = 1'b0;
            end
        end
    end

    // clock strobes
    always_comb begin
        cpu_tick_next = 1'b0;
        // cpu halts in idle and power-down; peripherals run in idle
        if (mode_reg == CMRP_RUN) begin
            cpu_tick_next = mc_tick;
        end
        for (int i = 0; i < NUM_PERIPH; i++) begin
            if (six_mode && !clk_rate_reg[CMRP_HALF_RATE_LSB + i]) begin
                periph_tick_next[i] = ticks.tick_fast;
            end else begin
                periph_tick_next[i] = ticks.tick_slow;
            end
        end
        // variable-rate serial modes are clocked by a timer, not this strobe
        uart_tick_next = uart_fixed_mode ? periph_tick_next[3] : 1'b0;
    end

    // static design: state simply holds while no ticks arrive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_rate_reg <= CMRP_CLK_RATE_RESET;
            idle_req_reg <= 1'b0;
            pdown_req_reg <= 1'b0;
            pof_reg <= 1'b1;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            mode_reg <= CMRP_RUN;
            rst_cnt_reg <= 2'h0;
            int_rst_reg <= 1'b0;
            ext_prog_reg <= 1'b0;
            ram_block_reg <= 1'b0;
            wake_irq_reg <= 1'b0;
            osc_run_reg <= 1'b1;
            cpu_tick_reg <= 1'b0;
            periph_tick_reg <= '0;
            uart_tick_reg <= 1'b0;
        end else begin
            clk_rate_reg <= clk_rate_next;
            idle_req_reg <= idle_req_next;
            pdown_req_reg <= pdown_req_next;
            pof_reg <= pof_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            mode_reg <= mode_next;
            rst_cnt_reg <= rst_cnt_next;
            int_rst_reg <= int_rst_next;
            ext_prog_reg <= ext_prog_next;
            ram_block_reg <= ram_block_next;
            wake_irq_reg <= wake_irq_next;
            osc_run_reg <= osc_run_next;
            cpu_tick_reg <= cpu_tick_next;
            periph_tick_reg <= periph_tick_next;
            uart_tick_reg <= uart_tick_next;
        end
    end

    // ports go to reset without waiting for an edge
    always_ff @(posedge pclk or posedge reset_pin or negedge presetn) begin
        if (reset_pin) begin
            port_reset_reg <= 1'b1;
        end else if (!presetn) begin
            port_reset_reg <= 1'b1;
        end else begin
            port_reset_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cpu_tick = cpu_tick_reg;
    assign periph_tick = periph_tick_reg;
    assign uart_tick = uart_tick_reg;
    assign osc_run = ticks.osc_run;
    assign internal_reset = int_rst_reg;
    assign ram_block = ram_block_reg;
    assign port_reset = port_reset_reg;
    assign ext_program_latched = ext_prog_reg;
    assign wake_irq = wake_irq_reg;
endmodule

//--- cmrp_ctrl_monitor.sv
// concurrent checks on the ports of the clock mode and power control block
`timescale 1ns/1ps
module cmrp_ctrl_monitor #(
    parameter int NUM_PERIPH = 6
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // pins and outputs
    input wire logic reset_pin,
    input wire logic uart_fixed_mode,
    input wire logic cpu_tick,
    input wire logic [NUM_PERIPH-1:0] periph_tick,
    input wire logic uart_tick,
    input wire logic osc_run,
    input wire logic internal_reset,
    input wire logic port_reset,
    input wire logic wake_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] hi_reg;
    logic [4:0] hi_next;
    // saturating count of edges with the reset pin high
    always_comb begin
        hi_next = reset_pin ? ((hi_reg == 5'h1F) ? hi_reg : hi_reg + 5'h01) : 5'h00;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_reg <= 5'h00;
        end else begin
            hi_reg <= hi_next;
        end
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_error_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("refused access with data");
    a_uart_from_div: assert property (uart_tick |-> periph_tick[3])
        else $error("uart tick without its divider tick");
    a_uart_var_mode: assert property (!uart_fixed_mode && $past(!uart_fixed_mode) |-> !uart_tick)
        else $error("uart tick in variable rate mode");
    a_periph_spacing: assert property (periph_tick[0] |=> !periph_tick[0] [*5])
        else $error("peripheral tick faster than six");
    a_cpu_spacing: assert property (cpu_tick |=> !cpu_tick [*5])
        else $error("cpu tick faster than six");
    a_stop_no_ticks: assert property (!osc_run [*3] |-> !cpu_tick && periph_tick == '0)
        else $error("ticks with oscillator stopped");
    a_port_async: assert property (reset_pin |-> port_reset)
        else $error("ports not in reset with pin high");
    a_reset_length: assert property ($rose(internal_reset) |-> hi_reg >= 5'h06)
        else $error("internal reset on a short pin pulse");
    a_reset_follows_pin: assert property (internal_reset && !reset_pin |-> ##[1:2] !internal_reset)
        else $error("internal reset outlives pin");
    a_wake_pulse: assert property (wake_irq |=> !wake_irq)
        else $error("wake pulse too long");
    c_refused: cover property (pslverr);
    c_wake: cover property (wake_irq);
    c_int_reset: cover property ($rose(internal_reset));
    c_uart: cover property (uart_tick);
endmodule

bind cmrp_ctrl cmrp_ctrl_monitor #(.NUM_PERIPH(NUM_PERIPH)) cmrp_ctrl_monitor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .reset_pin(reset_pin),
    .uart_fixed_mode(uart_fixed_mode), .cpu_tick(cpu_tick), .periph_tick(periph_tick), .uart_tick(uart_tick),
    .osc_run(osc_run), .internal_reset(internal_reset), .port_reset(port_reset), .wake_irq(wake_irq));

//--- cmrp_pins_model.sv
// model of the external reset source and wake interrupt pins
`timescale 1ns/1ps
module cmrp_pins_model (
    // clock
    input wire logic pclk,
    // pins toward the device
    output logic reset_pin,
    output logic ext_irq_zero_n,
    output logic ext_irq_one_n
);
    initial begin
        reset_pin = 1'b0;
        ext_irq_zero_n = 1'b1;
        ext_irq_one_n = 1'b1;
    end
    // caller picks a hold longer than two slow machine cycles
    task automatic hold_reset(input int cycles);
        @(posedge pclk);
        reset_pin <= 1'b1;
        repeat (cycles) @(posedge pclk);
        reset_pin <= 1'b0;
    endtask
    // pulled-up lines, so release returns them high
    task automatic level_wake(input bit one, input int cycles);
        @(posedge pclk);
        if (one) begin
            ext_irq_one_n <= 1'b0;
        end else begin
            ext_irq_zero_n <= 1'b0;
        end
        repeat (cycles) @(posedge pclk);
        ext_irq_zero_n <= 1'b1;
        ext_irq_one_n <= 1'b1;
    endtask
endmodule

//--- clock_mode_reset_power_control_test.sv
// self-checking bench for the clock mode, reset and power control block
`timescale 1ns/1ps
module clock_mode_reset_power_control_test;
    import cmrp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic reset_pin, ext_program_select, nv_double_speed, ext_irq_zero_n, ext_irq_one_n;
    logic zero_en, one_en, any_enabled_irq, uart_fixed_mode;
    logic cpu_tick, uart_tick, osc_run, internal_reset, ram_block, port_reset, ext_program_latched, wake_irq;
    logic [5:0] periph_tick;
    logic [6:0] ticks;
    logic [31:0] exp_q[$];
    int err_count = 0;
    int tests_run = 0;
    int seed = 69721;
    assign ticks = {cpu_tick, periph_tick};
    cmrp_ctrl cmrp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin(reset_pin),
        .ext_program_select(ext_program_select), .nv_double_speed(nv_double_speed), .ext_irq_zero_n(ext_irq_zero_n),
        .ext_irq_one_n(ext_irq_one_n), .ext_irq_zero_wake_en(zero_en), .ext_irq_one_wake_en(one_en),
        .any_enabled_irq(any_enabled_irq), .uart_fixed_mode(uart_fixed_mode), .cpu_tick(cpu_tick),
        .periph_tick(periph_tick), .uart_tick(uart_tick), .osc_run(osc_run), .internal_reset(internal_reset),
        .ram_block(ram_block), .port_reset(port_reset), .ext_program_latched(ext_program_latched), .wake_irq(wake_irq));
    cmrp_pins_model cmrp_pins_model_inst (.pclk(pclk), .reset_pin(reset_pin), .ext_irq_zero_n(ext_irq_zero_n),
        .ext_irq_one_n(ext_irq_one_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // expected read word carries the refusal flag in bit 31
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [31:0] expv);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        if (!wr) begin
            exp_q.push_back(expv);
        end
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // two ticks first so a fresh mode has settled
    task automatic gap(input int i, input int expv);
        int n;
        n = 0;
        repeat (2) @(posedge pclk iff ticks[i] === 1'b1);
        do begin
            @(posedge pclk);
            n++;
        end while (ticks[i] !== 1'b1 && n < 40);
        check(n, expv);
    endtask
    always @(posedge pclk) begin
        uart_fixed_mode <= 1'($random(seed));
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata[30:0]}, exp_q.pop_front());
        end
    end
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #300000;
        err_count++;
        complete_run();
    end
    initial begin
        logic [31:0] d;
        {presetn, psel, penable, pwrite, ext_program_select, nv_double_speed, zero_en, one_en} = 8'h00;
        {any_enabled_irq, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, CMRP_OFS_CLK_RATE, 0, {24'h00_0000, CMRP_CLK_RATE_RESET});
        apb(0, CMRP_OFS_PWR_CTRL, 0, 32'h0000_0010);
        apb(0, 12'h00C, 0, 32'h8000_0000);
        d = $random(seed);
        apb(1, CMRP_OFS_CLK_RATE, d, 0);
        apb(0, CMRP_OFS_CLK_RATE, 0, d & 32'h0000_007F);
        for (int i = 0; i < 6; i++) begin
            apb(1, CMRP_OFS_CLK_RATE, 32'h0000_0001, 0);
            gap(i, CMRP_OSC_PER_FAST);
            apb(1, CMRP_OFS_CLK_RATE, 32'h0000_0001 | (32'h0000_0001 << (i + 1)), 0);
            gap(i, CMRP_OSC_PER_SLOW);
        end
        gap(6, CMRP_OSC_PER_FAST);
        apb(1, CMRP_OFS_CLK_RATE, 0, 0);
        gap(0, CMRP_OSC_PER_SLOW);
        gap(6, CMRP_OSC_PER_SLOW);
        nv_double_speed <= 1'b1;
        gap(6, CMRP_OSC_PER_FAST);
        gap(0, CMRP_OSC_PER_FAST);
        apb(0, CMRP_OFS_STATUS, 0, 32'h0000_0001);
        nv_double_speed <= 1'b0;
        apb(1, CMRP_OFS_CLK_RATE, 32'h0000_0001, 0);
        apb(1, CMRP_OFS_PWR_CTRL, 32'h0000_0011, 0);
        apb(0, CMRP_OFS_STATUS, 0, 32'h0000_0003);
        gap(0, CMRP_OSC_PER_FAST);
        d = 0;
        repeat (14) begin
            @(posedge pclk);
            d = d + cpu_tick;
        end
        check(d, 0);
        any_enabled_irq <= 1'b1;
        @(posedge pclk iff wake_irq === 1'b1);
        any_enabled_irq <= 1'b0;
        apb(0, CMRP_OFS_PWR_CTRL, 0, 32'h0000_0010);
        for (int k = 0; k < 2; k++) begin
            zero_en <= (k == 0);
            one_en <= (k == 1);
            apb(1, CMRP_OFS_PWR_CTRL, 32'h0000_0012, 0);
            repeat (2) @(posedge pclk);
            check(osc_run, 0);
            fork
                cmrp_pins_model_inst.level_wake(k[0], 20);
                begin
                    repeat (6) @(posedge pclk);
                    check(osc_run, 1);
                end
            join
            @(posedge pclk iff wake_irq === 1'b1);
            apb(0, CMRP_OFS_PWR_CTRL, 0, 32'h0000_0010);
            apb(0, CMRP_OFS_CLK_RATE, 0, 32'h0000_0001);
        end
        apb(1, CMRP_OFS_PWR_CTRL, 32'h0000_0011, 0);
        ext_program_select <= 1'b1;
        fork
            cmrp_pins_model_inst.hold_reset(40);
            begin
                @(posedge reset_pin);
                #1;
                check(port_reset, 1);
                repeat (3) @(posedge pclk);
                check(ram_block, 1);
                @(posedge pclk iff internal_reset === 1'b1);
            end
        join
        repeat (4) @(posedge pclk);
        ext_program_select <= 1'b0;
        repeat (4) @(posedge pclk);
        check(ext_program_latched, 1);
        check(port_reset, 0);
        apb(0, CMRP_OFS_CLK_RATE, 0, 0);
        apb(0, CMRP_OFS_PWR_CTRL, 0, 32'h0000_0010);
        apb(0, CMRP_OFS_STATUS, 0, 32'h0000_0008);
        apb(1, CMRP_OFS_PWR_CTRL, 0, 0);
        apb(0, CMRP_OFS_PWR_CTRL, 0, 0);
        repeat (4) @(posedge pclk);
        complete_run();
    end
endmodule
